// file: pkg/rtf_defines.svh
// Register map, field positions and timing counts of the timer flag and interrupt block
// Contract
// - Rewriting reload while running may corrupt first period only; later reloads correct.
// - Countdown flag set drives interrupt pin only when countdown interrupt enabled.
// - First period after enable is uncertain by one source tick.
// - Countdown flag set at every period end; only software clears it.
// - Pulse-select picks pulse per event or level following flag for timer sources.
// - Countdown interrupt enable clear blocks pin drive; flag still sets.
// - Countdown register read returns live count, never frozen.
// - 1 Hz and 1/60 Hz periods follow correction-adjusted second chain.
// - Tick, countdown and alarm flags set by events and hold until overwritten.
// - Flag register write ANDs written bits with current flags.
// - Tick flag bit 5, alarm flag bit 3, countdown flag bit 2.
// - Interrupt pin active low; four sources wired-OR together.
// - Correction pulses 1/128 s; alarm follows flag level regardless of mode.
// - Pulsed tick interrupts last 1/64 s, counted as 512 oscillator ticks.
// - Clearing tick flag ends an active tick pulse immediately.
// - Level tick interrupt released on flag clear or both tick enables clear.
// - Countdown pulse width depends on source and whether reload equals one.
// - Flag clear cuts countdown pulse; enable clear releases level countdown drive.
// - With alarm enable set pin tracks alarm flag; clearing flag releases.
// - Writing one to correction interrupt bit shortens active correction pulse.
// - Reload zero stops timer; at count one flag sets and counter reloads.
// - Source select 00 4096 Hz, 01 64 Hz, 10 1 Hz, 11 1/60 Hz default.
// - Minute enable alone ticks per minute; second enable ticks per second.
`ifndef RTF_DEFINES_SVH
`define RTF_DEFINES_SVH

`define RTF_ADDR_CTRL1 8'h00
`define RTF_ADDR_CTRL2 8'h01
`define RTF_ADDR_TCLK 8'h0e
`define RTF_ADDR_COUNT 8'h0f

`define RTF_C1_TRIM_IRQ 2
`define RTF_C2_LONG_TICK 7
`define RTF_C2_SEC_TICK 6
`define RTF_C2_TICK_FLAG 5
`define RTF_C2_PULSE_SEL 4
`define RTF_C2_ALARM_FLAG 3
`define RTF_C2_DONE_FLAG 2
`define RTF_C2_ALARM_IRQ 1
`define RTF_C2_DONE_IRQ 0
`define RTF_TC_RUN 3

`define RTF_SEL_RESET 2'h3
`define RTF_RELOAD_RESET 8'h00

`define RTF_OSC_HZ 32768
`define RTF_DIV_4096 (`RTF_OSC_HZ / 4096)
`define RTF_DIV_64 (`RTF_OSC_HZ / 64)
`define RTF_W_8192 (`RTF_OSC_HZ / 8192)
`define RTF_W_4096 (`RTF_OSC_HZ / 4096)
`define RTF_W_128 (`RTF_OSC_HZ / 128)
`define RTF_W_64 (`RTF_OSC_HZ / 64)

`endif

// file: pkg/rtf_pkg.sv
// Types shared by the timer flag and interrupt block
package rtf_pkg;

	typedef enum logic [1:0] {
		RTF_SRC_4096 = 2'h0,
		RTF_SRC_64 = 2'h1,
		RTF_SRC_1HZ = 2'h2,
		RTF_SRC_MIN = 2'h3
	} rtf_src_t;

	// Incoming single-cycle event strobes from the surrounding clock chain
	typedef struct packed {
		logic osc32kTick;
		logic secTick;
		logic minTick;
		logic alarmMatch;
		logic trimPulse;
	} rtf_evt_t;

	// Host register access, one byte at a time
	typedef struct packed {
		logic wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} rtf_req_t;

	typedef enum logic {
		RTF_PS_IDLE,
		RTF_PS_ACTIVE
	} rtf_pstate_t;

endpackage

// file: logic/rtf_countdown.sv
// Reloading 8-bit countdown counter
`timescale 1ns/1ns
`include "rtf_defines.svh"
module rtf_countdown (
	input wire logic core_clk, // System clock
	input wire logic rst, // Synchronous reset, active high
	input wire logic run, // Countdown run enable
	input wire logic srcTick, // Selected source clock strobe
	input wire logic reloadWr, // Reload register written this cycle
	input wire logic [7:0] reloadVal, // Reload value n
	output logic [7:0] count, // Live count
	output logic doneEvt // One-cycle strobe at period end
);
	import rtf_pkg::*;

	logic [7:0] count_q;
	logic [7:0] reload_q;
	logic done_q;

	assign count = count_q;
	assign doneEvt = done_q;

	// ====================
	// Reload value
	// Kept here so that later periods never reload from whatever the bus carries now
	always_ff @(posedge core_clk) begin
		if (rst) begin
			reload_q <= `RTF_RELOAD_RESET;
		end else if (reloadWr) begin
			reload_q <= reloadVal;
		end
	end

	// ====================
	// Counter
	always_ff @(posedge core_clk) begin
		done_q <= 1'b0;
		if (rst) begin
			count_q <= `RTF_RELOAD_RESET;
		end else if (reloadWr) begin
			// New value takes effect at once; an in-flight tick may be lost here
			count_q <= reloadVal;
		end else if (run && srcTick && reload_q != 8'h00) begin
			if (count_q <= 8'h01) begin
				count_q <= reload_q;
				done_q <= 1'b1;
			end else begin
				count_q <= count_q - 8'h01;
			end
		end else if (!run) begin
			count_q <= reload_q;
		end
	end
endmodule // rtf_countdown

// file: logic/rtf_timer_irq.sv
// Timer flags, countdown control and open-drain interrupt output
`timescale 1ns/1ns
`include "rtf_defines.svh"
module rtf_timer_irq (
	input wire logic core_clk, // System clock, 10 MHz
	input wire logic rst, // Synchronous reset, active high
	input rtf_pkg::rtf_evt_t evt, // Event strobes from the clock chain
	input rtf_pkg::rtf_req_t req, // Host register write request
	output logic [7:0] regRdata, // Read data for req.addr, one cycle late
	output logic intOut, // Interrupt pin output level, always low
	output logic intOeN // Interrupt pin enable, low while pulling
);
	import rtf_pkg::*;

	// ====================
	// Register state
	logic trimIrqOn_q;
	logic longTickIrqOn_q;
	logic secTickIrqOn_q;
	logic tickFlag_q;
	logic timerIrqPulseSelect_q;
	logic alarmHitFlag_q;
	logic countDoneFlag_q;
	logic alarmIrqOn_q;
	logic countDoneIrqOn_q;
	logic countdownRunEnable_q;
	rtf_src_t countClockSelect_q;
	logic [7:0] reload_q;
	logic [7:0] rdata_q;
	logic intOeN_q;
	logic intOut_q;

	logic wrCtrl1;
	logic wrCtrl2;
	logic wrTclk;
	logic wrCount;

	assign wrCtrl1 = req.wr && req.addr == `RTF_ADDR_CTRL1;
	assign wrCtrl2 = req.wr && req.addr == `RTF_ADDR_CTRL2;
	assign wrTclk = req.wr && req.addr == `RTF_ADDR_TCLK;
	assign wrCount = req.wr && req.addr == `RTF_ADDR_COUNT;

	// ====================
	// Prescaler of the oscillator strobe
	logic [8:0] pre_q;
	logic tick4096;
	logic tick64;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			pre_q <= 9'h000;
		end else if (evt.osc32kTick) begin
			pre_q <= pre_q + 9'h001;
		end
	end

	assign tick4096 = evt.osc32kTick && pre_q[2:0] == 3'(`RTF_DIV_4096 - 1);
	assign tick64 = evt.osc32kTick && pre_q == 9'(`RTF_DIV_64 - 1);

	// ====================
	// Source decoding
	function automatic logic srcStrobe(input rtf_src_t sel, input logic t4096,
		input logic t64, input logic tSec, input logic tMin);
		case (sel)
			RTF_SRC_4096: srcStrobe = t4096;
			RTF_SRC_64: srcStrobe = t64;
			RTF_SRC_1HZ: srcStrobe = tSec;
			RTF_SRC_MIN: srcStrobe = tMin;
			default: srcStrobe = 1'b0;
		endcase
	endfunction

	// Countdown pulse width in oscillator ticks
	function automatic logic [9:0] doneWidth(input rtf_src_t sel, input logic [7:0] n);
		case (sel)
			RTF_SRC_4096: doneWidth = (n == 8'h01) ? 10'(`RTF_W_8192) : 10'(`RTF_W_4096);
			RTF_SRC_64: doneWidth = (n == 8'h01) ? 10'(`RTF_W_128) : 10'(`RTF_W_64);
			default: doneWidth = 10'(`RTF_W_64);
		endcase
	endfunction

	// ====================
	// First-period alignment
	// The slow sources only start counting on a 64 Hz edge after the enable, so the
	// first period of a 1 Hz or minute countdown is shifted by up to 1/64 s; fast
	// sources start on the next source tick and so run n-1 to n ticks.
	logic armed_q;
	logic srcRaw;
	logic srcTick;
	logic slowSrc;

	assign slowSrc = countClockSelect_q == RTF_SRC_1HZ || countClockSelect_q == RTF_SRC_MIN;
	assign srcRaw = srcStrobe(countClockSelect_q, tick4096, tick64, evt.secTick,
		evt.minTick);

	always_ff @(posedge core_clk) begin
		if (rst || !countdownRunEnable_q) begin
			armed_q <= 1'b0;
		end else if (!slowSrc || tick64) begin
			armed_q <= 1'b1;
		end
	end

	assign srcTick = armed_q && srcRaw;

	// ====================
	// Countdown counter
	logic [7:0] liveCount;
	logic doneEvt;

	rtf_countdown u_countdown (
		.core_clk(core_clk),
		.rst(rst),
		.run(countdownRunEnable_q),
		.srcTick(srcTick),
		.reloadWr(wrCount),
		.reloadVal(req.wdata),
		.count(liveCount),
		.doneEvt(doneEvt)
	);

	// ====================
	// Control registers
	always_ff @(posedge core_clk) begin
		if (rst) begin
			trimIrqOn_q <= 1'b0;
		end else if (wrCtrl1) begin
			trimIrqOn_q <= req.wdata[`RTF_C1_TRIM_IRQ];
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			longTickIrqOn_q <= 1'b0;
			secTickIrqOn_q <= 1'b0;
			timerIrqPulseSelect_q <= 1'b0;
			alarmIrqOn_q <= 1'b0;
			countDoneIrqOn_q <= 1'b0;
		end else if (wrCtrl2) begin
			// Non-flag bits store what was written; rewriting the same values is harmless
			longTickIrqOn_q <= req.wdata[`RTF_C2_LONG_TICK];
			secTickIrqOn_q <= req.wdata[`RTF_C2_SEC_TICK];
			timerIrqPulseSelect_q <= req.wdata[`RTF_C2_PULSE_SEL];
			alarmIrqOn_q <= req.wdata[`RTF_C2_ALARM_IRQ];
			countDoneIrqOn_q <= req.wdata[`RTF_C2_DONE_IRQ];
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			countdownRunEnable_q <= 1'b0;
			countClockSelect_q <= rtf_src_t'(`RTF_SEL_RESET);
		end else if (wrTclk) begin
			countdownRunEnable_q <= req.wdata[`RTF_TC_RUN];
			countClockSelect_q <= rtf_src_t'(req.wdata[1:0]);
		end
	end

	// Shadow of the reload value for pulse-width selection
	always_ff @(posedge core_clk) begin
		if (rst) begin
			reload_q <= `RTF_RELOAD_RESET;
		end else if (wrCount) begin
			reload_q <= req.wdata;
		end
	end

	// ====================
	// Event flags
	logic tickEvt;
	logic keepTick;
	logic keepAlarm;
	logic keepDone;

	// Second enable overrides minute enable
	assign tickEvt = secTickIrqOn_q ? evt.secTick : (longTickIrqOn_q && evt.minTick);

	// A zero written clears, a one keeps; an event in the same cycle still sets
	assign keepTick = !wrCtrl2 || req.wdata[`RTF_C2_TICK_FLAG];
	assign keepAlarm = !wrCtrl2 || req.wdata[`RTF_C2_ALARM_FLAG];
	assign keepDone = !wrCtrl2 || req.wdata[`RTF_C2_DONE_FLAG];

	always_ff @(posedge core_clk) begin
		if (rst) begin
			tickFlag_q <= 1'b0;
		end else begin
			tickFlag_q <= (tickFlag_q && keepTick) || tickEvt;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			alarmHitFlag_q <= 1'b0;
		end else begin
			alarmHitFlag_q <= (alarmHitFlag_q && keepAlarm) || evt.alarmMatch;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			countDoneFlag_q <= 1'b0;
		end else begin
			// No hardware path clears this flag
			countDoneFlag_q <= (countDoneFlag_q && keepDone) || doneEvt;
		end
	end

	// ====================
	// Pulse generators: 0 tick, 1 countdown, 2 correction
	logic [2:0] pStart;
	logic [2:0] pKill;
	logic [9:0] pWidth [3];
	logic [2:0] pActive;

	assign pStart[0] = tickEvt;
	assign pWidth[0] = 10'(`RTF_W_64);
	assign pKill[0] = !keepTick;

	assign pStart[1] = doneEvt;
	assign pWidth[1] = doneWidth(countClockSelect_q, reload_q);
	assign pKill[1] = !keepDone;

	assign pStart[2] = evt.trimPulse;
	assign pWidth[2] = 10'(`RTF_W_128);
	assign pKill[2] = wrCtrl1 && req.wdata[`RTF_C1_TRIM_IRQ];

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_pulse
			rtf_pstate_t st_q;
			logic [9:0] left_q;

			always_ff @(posedge core_clk) begin
				// A fresh event outranks a clear in the same cycle, as for the flags
				if (rst) begin
					st_q <= RTF_PS_IDLE;
					left_q <= 10'h000;
				end else if (pStart[gi]) begin
					st_q <= RTF_PS_ACTIVE;
					left_q <= pWidth[gi];
				end else if (pKill[gi]) begin
					st_q <= RTF_PS_IDLE;
					left_q <= 10'h000;
				end else begin
					case (st_q)
						RTF_PS_IDLE: begin
							left_q <= 10'h000;
						end
						RTF_PS_ACTIVE: begin
							if (evt.osc32kTick) begin
								left_q <= left_q - 10'h001;
								if (left_q <= 10'h001) begin
									st_q <= RTF_PS_IDLE;
								end
							end
						end
						default: begin
							st_q <= RTF_PS_IDLE;
						end
					endcase
				end
			end

			assign pActive[gi] = st_q == RTF_PS_ACTIVE;
		end
	endgenerate

	// ====================
	// Interrupt request merge
	logic tickReq;
	logic doneReq;
	logic alarmReq;
	logic trimReq;
	logic anyReq;

	always_comb begin
		if (timerIrqPulseSelect_q) begin
			tickReq = pActive[0] && (longTickIrqOn_q || secTickIrqOn_q);
			doneReq = pActive[1] && countDoneIrqOn_q;
		end else begin
			tickReq = tickFlag_q && (longTickIrqOn_q || secTickIrqOn_q);
			doneReq = countDoneFlag_q && countDoneIrqOn_q;
		end
	end

	// Alarm has no pulse form; the pin follows the flag directly
	assign alarmReq = alarmHitFlag_q && alarmIrqOn_q;
	assign trimReq = pActive[2] && trimIrqOn_q;
	// Wired-OR: while one source pulls low the others cannot be seen
	assign anyReq = tickReq || doneReq || alarmReq || trimReq;

	// The pin lags its cause by one cycle, far below any pulse width
	always_ff @(posedge core_clk) begin
		if (rst) begin
			intOeN_q <= 1'b1;
		end else begin
			intOeN_q <= !anyReq;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			intOut_q <= 1'b0;
		end else begin
			intOut_q <= 1'b0;
		end
	end

	assign intOut = intOut_q;
	assign intOeN = intOeN_q;

	// ====================
	// Read-back
	logic [7:0] ctrl2View;

	always_comb begin
		ctrl2View = 8'h00;
		ctrl2View[`RTF_C2_LONG_TICK] = longTickIrqOn_q;
		ctrl2View[`RTF_C2_SEC_TICK] = secTickIrqOn_q;
		ctrl2View[`RTF_C2_TICK_FLAG] = tickFlag_q;
		ctrl2View[`RTF_C2_PULSE_SEL] = timerIrqPulseSelect_q;
		ctrl2View[`RTF_C2_ALARM_FLAG] = alarmHitFlag_q;
		ctrl2View[`RTF_C2_DONE_FLAG] = countDoneFlag_q;
		ctrl2View[`RTF_C2_ALARM_IRQ] = alarmIrqOn_q;
		ctrl2View[`RTF_C2_DONE_IRQ] = countDoneIrqOn_q;
	end

	// The count is sampled while it runs; a read may straddle a decrement
	always_ff @(posedge core_clk) begin
		if (rst) begin
			rdata_q <= 8'h00;
		end else begin
			case (req.addr)
				`RTF_ADDR_CTRL1: rdata_q <= 8'(trimIrqOn_q) << `RTF_C1_TRIM_IRQ;
				`RTF_ADDR_CTRL2: rdata_q <= ctrl2View;
				`RTF_ADDR_TCLK: rdata_q <= {4'h0, countdownRunEnable_q, 1'b0,
					countClockSelect_q};
				`RTF_ADDR_COUNT: rdata_q <= liveCount;
				default: rdata_q <= 8'h00;
			endcase
		end
	end

	assign regRdata = rdata_q;
endmodule // rtf_timer_irq

// file: verif/rtf_timer_irq_chk.sv
// Port checker for the timer flag and interrupt block
`timescale 1ns/1ns
module rtf_timer_irq_chk (
	input wire logic core_clk, // Clock
	input wire logic rst, // Reset
	input rtf_pkg::rtf_evt_t evt, // Events
	input rtf_pkg::rtf_req_t req, // Host request
	input wire logic [7:0] regRdata, // Read data
	input wire logic intOut, // Pin level
	input wire logic intOeN // Pin enable
);
	import rtf_pkg::*;
	// ==========
	// Shadow of the enables: b4 min, b3 sec, b2 trim, b1 alarm, b0 done
	logic [4:0] irqEn_q;
	logic wr1;
	assign wr1 = req.wr && req.addr == 8'h01;
	always_ff @(posedge core_clk) begin
		if (rst) begin
			irqEn_q <= 5'h00;
		end else if (wr1) begin
			irqEn_q <= {req.wdata[7:6], irqEn_q[2], req.wdata[1:0]};
		end else if (req.wr && req.addr == 8'h00) begin
			irqEn_q[2] <= req.wdata[2];
		end
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	// ==========
	// Assertions
	a_pin_level: assert property (intOut == 1'b0)
		else $error("pin drive level not low");
	a_reset_idle: assert property ($past(rst) |-> intOeN && regRdata == 8'h00)
		else $error("outputs not idle after reset");
	a_unmapped_zero: assert property (req.addr == 8'h05 |=> regRdata == 8'h00)
		else $error("unmapped read not zero");
	a_flag_and: assert property (wr1 && !req.wdata[5] && !evt.secTick && !evt.minTick
		##1 req.addr == 8'h01 |=> !regRdata[5])
		else $error("tick flag survived a zero write");
	a_alarm_set: assert property (evt.alarmMatch ##1 req.addr == 8'h01 |=> regRdata[3])
		else $error("alarm flag not set");
	a_done_hold: assert property (req.addr == 8'h01 && !req.wr ##1 req.addr == 8'h01
		|=> regRdata[2] >= $past(regRdata[2]))
		else $error("countdown flag fell without a write");
	a_alarm_pin: assert property (evt.alarmMatch && irqEn_q[1] && !wr1 |-> ##2 !intOeN)
		else $error("alarm did not pull the pin");
	a_pin_quiet: assert property ((irqEn_q == 5'h00)[*3] |-> intOeN)
		else $error("pin pulled with all sources disabled");
	a_trim_kill: assert property (req.wr && req.addr == 8'h00 && req.wdata[2] && !evt.trimPulse
		&& irqEn_q[4:3] == 2'h0 && irqEn_q[1:0] == 2'h0 |=> ##1 intOeN)
		else $error("correction pulse not cut");
	c_alarm: cover property (evt.alarmMatch && irqEn_q[1]);
	c_fall: cover property ($fell(intOeN));
	c_trim: cover property (evt.trimPulse && irqEn_q[2]);
endmodule // rtf_timer_irq_chk

// file: verif/rtf_host_pin.sv
// Host-side view of the open-drain interrupt wire
`timescale 1ns/1ns
module rtf_host_pin (
	input wire logic core_clk, // Clock
	input wire logic intOut, // Device drive level
	input wire logic intOeN, // Device enable, low pulls
	output logic pinLvl, // Wire level
	output logic [15:0] lowLen // Cycles of the last low phase
);
	logic [15:0] run = 16'h0;
	logic [15:0] lowLen_q = 16'h0;
	assign lowLen = lowLen_q;
	// Pull-up wins whenever the device lets go
	assign pinLvl = intOeN ? 1'b1 : intOut;
	always @(posedge core_clk) begin
		if (pinLvl !== 1'b1) begin
			run <= run + 16'h1;
		end else if (run != 16'h0) begin
			lowLen_q <= run;
			run <= 16'h0;
		end
	end
endmodule // rtf_host_pin

// file: verif/rtf_timer_irq_tb.sv
// Self-checking bench for the timer flag and interrupt block
`timescale 1ns/1ns
module rtf_timer_irq_tb;
	import rtf_pkg::*;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	rtf_evt_t evt;
	logic secStb = 1'b0;
	logic minStb = 1'b0;
	logic [1:0] evStb = 2'b00;
	rtf_req_t req = '0;
	logic [7:0] regRdata;
	logic intOut;
	logic intOeN;
	logic pinLvl;
	logic [15:0] lowLen;
	logic [7:0] rv;
	logic [7:0] rv2;
	logic slowOn = 1'b0;
	int tk = 0;
	int bad_count = 0;
	int n_checks = 0;
	logic [7:0] adr [5] = '{8'h00, 8'h01, 8'h0e, 8'h0f, 8'h05};
	logic [7:0] rstv [5] = '{8'h00, 8'h00, 8'h03, 8'h00, 8'h00};
	logic [1:0] srcT [6] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h3};
	logic [7:0] nT [6] = '{8'h01, 8'h03, 8'h01, 8'h02, 8'h01, 8'h01};
	logic [15:0] wT [6] = '{16'h4, 16'h8, 16'h100, 16'h200, 16'h200, 16'h200};

	rtf_timer_irq dut_u (.core_clk(core_clk), .rst(rst), .evt(evt), .req(req),
		.regRdata(regRdata), .intOut(intOut), .intOeN(intOeN));
	rtf_host_pin host_u (.core_clk(core_clk), .intOut(intOut), .intOeN(intOeN),
		.pinLvl(pinLvl), .lowLen(lowLen));

	initial begin
		forever #50 core_clk = ~core_clk;
	end
	// Oscillator strobe every cycle; alarm and correction strobes come from ev
	assign evt = {1'b1, secStb, minStb, evStb};
	// Second and minute strobes every 700 cycles, half a period apart to tell them apart
	always @(posedge core_clk) begin
		tk <= (tk == 699) ? 0 : tk + 1;
		secStb <= slowOn && tk == 0;
		minStb <= slowOn && tk == 350;
	end
	// ==========
	// Tasks
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		req <= '{1'b1, a, d};
		@(posedge core_clk);
		req.wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge core_clk);
		req.addr <= a;
		@(posedge core_clk);
		@(negedge core_clk);
		d = regRdata;
	endtask
	task automatic ev(input logic [1:0] m);
		@(posedge core_clk);
		evStb <= m;
		@(posedge core_clk);
		evStb <= 2'b00;
	endtask
	task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_checks++;
		if (g !== e) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chkw(input string nm, input logic [15:0] lo, input logic [15:0] hi,
		input logic [15:0] g);
		n_checks++;
		if (((g >= lo) && (g <= hi)) !== 1'b1) begin
			bad_count++;
			$display("[FAIL] %s expected %0d..%0d seen %0d", nm, lo, hi, g);
		end
	endtask
	task automatic waitPin(input logic lv, input int lim);
		int i;
		i = 0;
		do begin
			@(negedge core_clk);
			i++;
		end while (pinLvl !== lv && i < lim);
		chk8("pin", {7'h0, lv}, {7'h0, pinLvl});
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	initial begin
		#(100 * 40000);
		bad_count++;
		summarize();
	end
	// ==========
	// Sequence
	initial begin
		repeat (5) @(posedge core_clk);
		rst <= 1'b0;
		for (int i = 0; i < 5; i++) begin
			rd(adr[i], rv);
			chk8("reset value", rstv[i], rv);
		end
		wr(8'h01, 8'h42);
		slowOn <= 1'b1;
		waitPin(1'b0, 800);
		slowOn <= 1'b0;
		rd(8'h01, rv);
		chk8("ctrl2", 8'h62, rv);
		repeat (600) @(posedge core_clk);
		waitPin(1'b0, 1);
		ev(2'b10);
		rd(8'h01, rv);
		chk8("ctrl2", 8'h6a, rv);
		wr(8'h01, 8'h4a);
		rd(8'h01, rv);
		chk8("ctrl2", 8'h4a, rv);
		waitPin(1'b0, 1);
		wr(8'h01, 8'h42);
		waitPin(1'b1, 3);
		slowOn <= 1'b1;
		waitPin(1'b0, 800);
		slowOn <= 1'b0;
		wr(8'h01, 8'h22);
		waitPin(1'b1, 3);
		wr(8'h01, 8'h50);
		slowOn <= 1'b1;
		waitPin(1'b0, 800);
		waitPin(1'b1, 600);
		slowOn <= 1'b0;
		// The host model latches the low length one edge after release
		@(negedge core_clk);
		chkw("tick width", 16'd511, 16'd513, lowLen);
		slowOn <= 1'b1;
		waitPin(1'b0, 800);
		slowOn <= 1'b0;
		repeat (20) @(posedge core_clk);
		wr(8'h01, 8'h50);
		waitPin(1'b1, 3);
		// Minute enable alone: only the minute strobe may set the flag
		wr(8'h01, 8'h80);
		slowOn <= 1'b1;
		waitPin(1'b0, 800);
		chkw("minute tick phase", 16'd351, 16'd355, 16'(tk));
		slowOn <= 1'b0;
		for (int i = 0; i < 6; i++) begin
			slowOn <= srcT[i][1];
			wr(8'h01, 8'h11);
			wr(8'h0f, nT[i]);
			wr(8'h0e, {6'h02, srcT[i]});
			waitPin(1'b0, 3000);
			waitPin(1'b1, 600);
			@(negedge core_clk);
			chkw("countdown width", wT[i] - 16'h1, wT[i] + 16'h1, lowLen);
			rd(8'h01, rv);
			chk8("ctrl2", 8'h15, rv);
			wr(8'h0e, 8'h03);
			wr(8'h01, 8'h00);
		end
		slowOn <= 1'b0;
		wr(8'h01, 8'h10);
		wr(8'h0f, 8'hc8);
		wr(8'h0e, 8'h08);
		repeat (160) @(posedge core_clk);
		// Count moves under the read, so only two equal reads are trusted
		do begin
			rd(8'h0f, rv);
			rd(8'h0f, rv2);
		end while (rv !== rv2);
		chkw("live count", 16'd178, 16'd181, {8'h0, rv});
		repeat (1700) @(posedge core_clk);
		rd(8'h01, rv);
		chk8("ctrl2", 8'h14, rv);
		waitPin(1'b1, 1);
		wr(8'h01, 8'h05);
		waitPin(1'b0, 3);
		wr(8'h01, 8'h04);
		waitPin(1'b1, 3);
		wr(8'h0f, 8'h00);
		repeat (40) @(posedge core_clk);
		rd(8'h0f, rv);
		chk8("count", 8'h00, rv);
		wr(8'h0e, 8'h03);
		wr(8'h01, 8'h00);
		wr(8'h00, 8'h04);
		ev(2'b01);
		waitPin(1'b0, 5);
		waitPin(1'b1, 400);
		@(negedge core_clk);
		chkw("trim width", 16'd255, 16'd257, lowLen);
		ev(2'b01);
		waitPin(1'b0, 5);
		wr(8'h00, 8'h04);
		waitPin(1'b1, 3);
		rd(8'h00, rv);
		chk8("ctrl1", 8'h04, rv);
		summarize();
	end
endmodule // rtf_timer_irq_tb

bind rtf_timer_irq rtf_timer_irq_chk chk_u (.core_clk(core_clk), .rst(rst), .evt(evt),
	.req(req), .regRdata(regRdata), .intOut(intOut), .intOeN(intOeN));
